// ### design/dus_bank.sv
// dus_bank: scaling, boot delay and fieldbus select parameter bank.
// assumes object access and conversion requests come from logic on the same clock.
// Functional notes
// - compensation one: pole pairs enter motion values
// - compensation zero: pole pairs not added
// - velocity scaled by numerator over denominator
// - acceleration scaled by numerator over denominator
// - jerk scaled by numerator over denominator
// - ready only after boot delay milliseconds
// - bits 0-15 interfaces, 16-31 protocols
// - interface bit one when present
// - protocol bit one when in use
// - control word enables buses, preset CANopen
// - fixed bit positions per interface, protocol
// - separate read-only active bus status
`timescale 1ns/1ns
module dus_bank #(
	parameter logic [31:0] BUS_AVAIL  = dus_pkg::RST_BUS_AVAIL,
	parameter int          CYC_PER_MS = dus_pkg::CYC_PER_MS
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// object dictionary access
	input  wire logic        od_req,
	input  wire logic        od_we,
	input  wire logic [15:0] od_index,
	input  wire logic [31:0] od_wdata,
	output logic             od_ack,
	output logic             od_err,
	output logic [31:0]      od_rdata,
	// conversion request
	input  wire logic        cv_start,
	input  wire logic [1:0]  cv_kind,
	input  wire logic [31:0] cv_value,
	input  wire logic [7:0]  pole_pairs,
	output logic             cv_done,
	output logic             cv_error,
	output logic [31:0]      cv_result,
	// status
	output logic             ready,
	output logic [31:0]      bus_enabled
);
	dus_conv_if cvi ();

	dus_convert u_conv (
		.clock (clock),
		.rst_n (rst_n),
		.cv    (cvi.unit)
	);

	// register bank
	logic [31:0] pole_comp_reg,  pole_comp_next;
	logic [31:0] vel_num_reg,    vel_num_next;
	logic [31:0] vel_den_reg,    vel_den_next;
	logic [31:0] acc_num_reg,    acc_num_next;
	logic [31:0] acc_den_reg,    acc_den_next;
	logic [31:0] jerk_num_reg,   jerk_num_next;
	logic [31:0] jerk_den_reg,   jerk_den_next;
	logic [31:0] boot_delay_reg, boot_delay_next;
	logic [31:0] bus_ctrl_reg,   bus_ctrl_next;
	logic        ack_reg,        ack_next;
	logic        err_reg,        err_next;
	logic [31:0] rdata_reg,      rdata_next;
	logic [31:0] bus_en_reg,     bus_en_next;
	logic        wr;

	always_comb begin
		pole_comp_next  = pole_comp_reg;
		vel_num_next    = vel_num_reg;
		vel_den_next    = vel_den_reg;
		acc_num_next    = acc_num_reg;
		acc_den_next    = acc_den_reg;
		jerk_num_next   = jerk_num_reg;
		jerk_den_next   = jerk_den_reg;
		boot_delay_next = boot_delay_reg;
		bus_ctrl_next   = bus_ctrl_reg;
		ack_next        = od_req;
		err_next        = 1'b0;
		rdata_next      = 32'h00000000;
		wr              = od_req && od_we;
		if (od_req) begin
			case (od_index)
				dus_pkg::IDX_POLE_COMP: begin
					rdata_next = pole_comp_reg;
					if (wr) pole_comp_next = od_wdata;
				end
				dus_pkg::IDX_VEL_NUM: begin
					rdata_next = vel_num_reg;
					if (wr) vel_num_next = od_wdata;
				end
				dus_pkg::IDX_VEL_DEN: begin
					rdata_next = vel_den_reg;
					if (wr && od_wdata == 32'h00000000) err_next = 1'b1;
					else if (wr) vel_den_next = od_wdata;
				end
				dus_pkg::IDX_ACC_NUM: begin
					rdata_next = acc_num_reg;
					if (wr) acc_num_next = od_wdata;
				end
				dus_pkg::IDX_ACC_DEN: begin
					rdata_next = acc_den_reg;
					if (wr && od_wdata == 32'h00000000) err_next = 1'b1;
					else if (wr) acc_den_next = od_wdata;
				end
				dus_pkg::IDX_JERK_NUM: begin
					rdata_next = jerk_num_reg;
					if (wr) jerk_num_next = od_wdata;
				end
				dus_pkg::IDX_JERK_DEN: begin
					rdata_next = jerk_den_reg;
					if (wr && od_wdata == 32'h00000000) err_next = 1'b1;
					else if (wr) jerk_den_next = od_wdata;
				end
				dus_pkg::IDX_BOOT_DELAY: begin
					rdata_next = boot_delay_reg;
					if (wr) boot_delay_next = od_wdata;
				end
				dus_pkg::IDX_BUS_AVAIL: begin
					rdata_next = BUS_AVAIL & dus_pkg::BUS_DEFINED_MASK;
					err_next   = wr;
				end
				dus_pkg::IDX_BUS_CTRL: begin
					rdata_next = bus_ctrl_reg;
					if (wr) bus_ctrl_next = od_wdata;
				end
				dus_pkg::IDX_BUS_STATUS: begin
					rdata_next = bus_en_reg;
					err_next   = wr;
				end
				default: begin
					err_next = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pole_comp_reg  <= dus_pkg::RST_POLE_COMP;
			vel_num_reg    <= dus_pkg::RST_NUM;
			vel_den_reg    <= dus_pkg::RST_DEN;
			acc_num_reg    <= dus_pkg::RST_NUM;
			acc_den_reg    <= dus_pkg::RST_DEN;
			jerk_num_reg   <= dus_pkg::RST_NUM;
			jerk_den_reg   <= dus_pkg::RST_DEN;
			boot_delay_reg <= dus_pkg::RST_BOOT_DELAY;
			bus_ctrl_reg   <= dus_pkg::RST_BUS_CTRL;
			ack_reg        <= 1'b0;
			err_reg        <= 1'b0;
			rdata_reg      <= 32'h00000000;
		end else begin
			pole_comp_reg  <= pole_comp_next;
			vel_num_reg    <= vel_num_next;
			vel_den_reg    <= vel_den_next;
			acc_num_reg    <= acc_num_next;
			acc_den_reg    <= acc_den_next;
			jerk_num_reg   <= jerk_num_next;
			jerk_den_reg   <= jerk_den_next;
			boot_delay_reg <= boot_delay_next;
			bus_ctrl_reg   <= bus_ctrl_next;
			ack_reg        <= ack_next;
			err_reg        <= err_next;
			rdata_reg      <= rdata_next;
		end
	end

	// active buses and boot delay
	logic [31:0]              ms_cnt_reg,   ms_cnt_next;
	logic [31:0]              tick_cnt_reg, tick_cnt_next;
	dus_pkg::dus_boot_state_t boot_reg,     boot_next;

	always_comb begin
		bus_en_next   = bus_ctrl_reg & BUS_AVAIL & dus_pkg::BUS_DEFINED_MASK;
		boot_next     = boot_reg;
		ms_cnt_next   = ms_cnt_reg;
		tick_cnt_next = tick_cnt_reg;
		case (boot_reg)
			dus_pkg::DUS_BOOT_WAIT: begin
				if (ms_cnt_reg >= boot_delay_reg) begin
					boot_next = dus_pkg::DUS_BOOT_READY;
				end else if (tick_cnt_reg == 32'(CYC_PER_MS - 1)) begin
					tick_cnt_next = 32'h00000000;
					ms_cnt_next   = ms_cnt_reg + 32'h00000001;
				end else begin
					tick_cnt_next = tick_cnt_reg + 32'h00000001;
				end
			end
			dus_pkg::DUS_BOOT_READY: begin
				boot_next = dus_pkg::DUS_BOOT_READY;
			end
			default: begin
				boot_next = dus_pkg::DUS_BOOT_WAIT;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_en_reg   <= dus_pkg::RST_BUS_CTRL;
			ms_cnt_reg   <= 32'h00000000;
			tick_cnt_reg <= 32'h00000000;
			boot_reg     <= dus_pkg::DUS_BOOT_WAIT;
		end else begin
			bus_en_reg   <= bus_en_next;
			ms_cnt_reg   <= ms_cnt_next;
			tick_cnt_reg <= tick_cnt_next;
			boot_reg     <= boot_next;
		end
	end

	// conversion launch and result capture
	logic        start_reg,  start_next;
	logic [1:0]  kind_reg,   kind_next;
	logic [31:0] value_reg,  value_next;
	logic        done_reg,   done_next;
	logic        cerr_reg,   cerr_next;
	logic [31:0] result_reg, result_next;

	always_comb begin
		start_next  = cv_start;
		kind_next   = cv_start ? cv_kind : kind_reg;
		value_next  = cv_start ? cv_value : value_reg;
		done_next   = cvi.done;
		cerr_next   = cvi.done ? cvi.error : cerr_reg;
		result_next = cvi.done ? cvi.result : result_reg;
		cvi.start      = start_reg;
		cvi.value      = value_reg;
		cvi.comp       = (pole_comp_reg == 32'h00000001);
		cvi.pole_pairs = pole_pairs;
		case (kind_reg)
			dus_pkg::DUS_KIND_ACC: begin
				cvi.num = acc_num_reg;
				cvi.den = acc_den_reg;
			end
			dus_pkg::DUS_KIND_JERK: begin
				cvi.num = jerk_num_reg;
				cvi.den = jerk_den_reg;
			end
			default: begin
				cvi.num = vel_num_reg;
				cvi.den = vel_den_reg;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start_reg  <= 1'b0;
			kind_reg   <= 2'b00;
			value_reg  <= 32'h00000000;
			done_reg   <= 1'b0;
			cerr_reg   <= 1'b0;
			result_reg <= 32'h00000000;
		end else begin
			start_reg  <= start_next;
			kind_reg   <= kind_next;
			value_reg  <= value_next;
			done_reg   <= done_next;
			cerr_reg   <= cerr_next;
			result_reg <= result_next;
		end
	end

	assign od_ack      = ack_reg;
	assign od_err      = err_reg;
	assign od_rdata    = rdata_reg;
	assign cv_done     = done_reg;
	assign cv_error    = cerr_reg;
	assign cv_result   = result_reg;
	assign ready       = (boot_reg == dus_pkg::DUS_BOOT_READY);
	assign bus_enabled = bus_en_reg;
endmodule : dus_bank

// ### design/dus_pkg.sv
// dus_pkg: constants of the drive scaling and fieldbus select bank.
// assumes a single 25 MHz clock domain for every user of these constants.
package dus_pkg;
	localparam int          CLK_HZ         = 25000000;
	localparam int          MS_PER_S       = 1000;
	localparam int          TICK_MS        = 1;
	localparam int          CYC_PER_MS     = (CLK_HZ / MS_PER_S) * TICK_MS;
	localparam logic [15:0] IDX_POLE_COMP  = 16'h2060;
	localparam logic [15:0] IDX_VEL_NUM    = 16'h2061;
	localparam logic [15:0] IDX_VEL_DEN    = 16'h2062;
	localparam logic [15:0] IDX_ACC_NUM    = 16'h2063;
	localparam logic [15:0] IDX_ACC_DEN    = 16'h2064;
	localparam logic [15:0] IDX_JERK_NUM   = 16'h2065;
	localparam logic [15:0] IDX_JERK_DEN   = 16'h2066;
	localparam logic [15:0] IDX_BOOT_DELAY = 16'h2084;
	localparam logic [15:0] IDX_BUS_AVAIL  = 16'h2101;
	localparam logic [15:0] IDX_BUS_CTRL   = 16'h2102;
	localparam logic [15:0] IDX_BUS_STATUS = 16'h2103;
	localparam logic [31:0] RST_POLE_COMP  = 32'h00000001;
	localparam logic [31:0] RST_NUM        = 32'h00000001;
	localparam logic [31:0] RST_DEN        = 32'h0000003C;
	localparam logic [31:0] RST_BOOT_DELAY = 32'h00000000;
	localparam logic [31:0] RST_BUS_AVAIL  = 32'h00000008;
	localparam logic [31:0] RST_BUS_CTRL   = 32'h00000008;
	localparam int          PHY_LSB        = 0;
	localparam int          PHY_MSB        = 15;
	localparam int          PROTO_LSB      = 16;
	localparam int          PROTO_MSB      = 31;
	localparam int          USB_BIT                    = 0;
	localparam int          RS485_BIT                  = 1;
	localparam int          RS232_BIT                  = 2;
	localparam int          CANOPEN_BIT                = 3;
	localparam int          ETHERNET_PHY_BIT           = 4;
	localparam int          INDUSTRIAL_ETHERNET_BIT    = 5;
	localparam int          SPI_BIT                    = 6;
	localparam int          SERIAL_MODBUS_PROTOCOL_BIT = 16;
	localparam int          TCP_MODBUS_PROTOCOL_BIT    = 17;
	localparam int          INDUSTRIAL_IP_PROTOCOL_BIT = 18;
	localparam logic [31:0] BUS_DEFINED_MASK = 32'h0007007F;
	localparam int          PROD_W         = 72;
	localparam logic [6:0]  DIV_STEPS      = 7'h48;
	typedef enum logic [1:0] {
		DUS_KIND_VEL  = 2'b00,
		DUS_KIND_ACC  = 2'b01,
		DUS_KIND_JERK = 2'b10
	} dus_kind_t;
	typedef enum logic [1:0] {
		DUS_DIV_IDLE = 2'b00,
		DUS_DIV_RUN  = 2'b01,
		DUS_DIV_DONE = 2'b10
	} dus_div_state_t;
	typedef enum logic [0:0] {
		DUS_BOOT_WAIT  = 1'b0,
		DUS_BOOT_READY = 1'b1
	} dus_boot_state_t;
endpackage : dus_pkg

// ### design/dus_conv_if.sv
// dus_conv_if: request and answer of one unit conversion.
// assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface dus_conv_if;
	logic        start;
	logic [31:0] value;
	logic [31:0] num;
	logic [31:0] den;
	logic        comp;
	logic [7:0]  pole_pairs;
	logic        done;
	logic [31:0] result;
	logic        error;
	modport ctrl (output start, value, num, den, comp, pole_pairs, input done, result, error);
	modport unit (input start, value, num, den, comp, pole_pairs, output done, result, error);
endinterface : dus_conv_if

// ### design/dus_convert.sv
// dus_convert: value * num (* pole pairs) / den by serial restoring division.
// assumes inputs stay stable for the cycle in which start is high.
`timescale 1ns/1ns
module dus_convert (
	// clock and reset
	input  wire logic  clock,
	input  wire logic  rst_n,
	// conversion request
	dus_conv_if.unit   cv
);
	dus_pkg::dus_div_state_t state_reg, state_next;
	logic [32:0]                rem_reg, rem_next;
	logic [dus_pkg::PROD_W-1:0] quo_reg, quo_next;
	logic [6:0]                 cnt_reg, cnt_next;
	logic [31:0]                den_reg, den_next;
	logic                       done_reg, done_next;
	logic                       err_reg, err_next;
	logic [31:0]                res_reg, res_next;
	logic [32:0]                rem_shift;
	logic [63:0]                prod_base;
	logic [7:0]                 pp_factor;

	always_comb begin
		state_next = state_reg;
		rem_next   = rem_reg;
		quo_next   = quo_reg;
		cnt_next   = cnt_reg;
		den_next   = den_reg;
		done_next  = 1'b0;
		err_next   = err_reg;
		res_next   = res_reg;
		prod_base  = 64'(cv.value) * 64'(cv.num);
		pp_factor  = cv.comp ? cv.pole_pairs : 8'h01;
		rem_shift  = {rem_reg[31:0], quo_reg[dus_pkg::PROD_W-1]};
		case (state_reg)
			dus_pkg::DUS_DIV_IDLE: begin
				if (cv.start) begin
					if (cv.den == 32'h00000000) begin
						err_next   = 1'b1;
						res_next   = 32'h00000000;
						state_next = dus_pkg::DUS_DIV_DONE;
					end else begin
						quo_next   = 72'(prod_base) * 72'(pp_factor);
						rem_next   = 33'h000000000;
						den_next   = cv.den;
						cnt_next   = dus_pkg::DIV_STEPS;
						state_next = dus_pkg::DUS_DIV_RUN;
					end
				end
			end
			dus_pkg::DUS_DIV_RUN: begin
				if (rem_shift >= {1'b0, den_reg}) begin
					rem_next = rem_shift - {1'b0, den_reg};
					quo_next = {quo_reg[dus_pkg::PROD_W-2:0], 1'b1};
				end else begin
					rem_next = rem_shift;
					quo_next = {quo_reg[dus_pkg::PROD_W-2:0], 1'b0};
				end
				cnt_next = cnt_reg - 7'h01;
				if (cnt_reg == 7'h01) begin
					state_next = dus_pkg::DUS_DIV_DONE;
				end
			end
			dus_pkg::DUS_DIV_DONE: begin
				if (!err_reg) begin
					res_next = quo_reg[31:0];
					err_next = |quo_reg[dus_pkg::PROD_W-1:32];
				end
				done_next  = 1'b1;
				state_next = dus_pkg::DUS_DIV_IDLE;
			end
			default: begin
				state_next = dus_pkg::DUS_DIV_IDLE;
			end
		endcase
		if (state_reg == dus_pkg::DUS_DIV_IDLE && cv.start) begin
			err_next = (cv.den == 32'h00000000);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= dus_pkg::DUS_DIV_IDLE;
			rem_reg   <= 33'h000000000;
			quo_reg   <= 72'h0;
			cnt_reg   <= 7'h00;
			den_reg   <= 32'h00000000;
			done_reg  <= 1'b0;
			err_reg   <= 1'b0;
			res_reg   <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			rem_reg   <= rem_next;
			quo_reg   <= quo_next;
			cnt_reg   <= cnt_next;
			den_reg   <= den_next;
			done_reg  <= done_next;
			err_reg   <= err_next;
			res_reg   <= res_next;
		end
	end

	assign cv.done   = done_reg;
	assign cv.result = res_reg;
	assign cv.error  = err_reg;
endmodule : dus_convert

// ### test/dus_bank_properties.sv
// dus_bank_properties: port checker of the scaling and bus select bank.
// assumes one clock and an async active-low reset.
`timescale 1ns/1ns
module dus_bank_properties #(
	parameter logic [31:0] BUS_AVAIL  = dus_pkg::RST_BUS_AVAIL,
	parameter int          CYC_PER_MS = dus_pkg::CYC_PER_MS
) (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// object access
	input wire logic        od_req,
	input wire logic        od_we,
	input wire logic [15:0] od_index,
	input wire logic [31:0] od_wdata,
	input wire logic        od_ack,
	input wire logic        od_err,
	input wire logic [31:0] od_rdata,
	// conversion
	input wire logic        cv_start,
	input wire logic        cv_done,
	// status
	input wire logic        ready,
	input wire logic [31:0] bus_enabled
);
	logic busy_reg;
	logic busy_next;
	always_comb begin
		busy_next = busy_reg;
		if (cv_done)
			busy_next = 1'b0;
		else if (cv_start)
			busy_next = 1'b1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			busy_reg <= 1'b0;
		else
			busy_reg <= busy_next;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_den_zero;
		od_req && od_we && od_wdata == 32'h0 && od_index inside {16'h2062, 16'h2064, 16'h2066};
	endsequence
	sequence s_conv_wait;
		(!cv_done)[*2] ##[1:74] cv_done;
	endsequence
	a_ack_next: assert property (od_req |=> od_ack) else $error("no answer after request");
	a_ack_idle: assert property (!od_req |=> !od_ack) else $error("answer without request");
	a_rdata_idle: assert property (!od_ack |-> od_rdata == 32'h0 && !od_err) else $error("read data outside answer");
	a_ro_refused: assert property (od_req && od_we && od_index == 16'h2101 |=> od_err) else $error("write to ro word taken");
	a_den_refused: assert property (s_den_zero |=> od_err) else $error("zero denominator taken");
	a_bus_masked: assert property ((bus_enabled & ~(BUS_AVAIL & dus_pkg::BUS_DEFINED_MASK)) == 32'h0)
		else $error("unavailable bus enabled");
	a_bus_follow: assert property (od_req && od_we && od_index == 16'h2102 |-> ##2
		bus_enabled == ($past(od_wdata, 2) & BUS_AVAIL & dus_pkg::BUS_DEFINED_MASK)) else $error("bus enable late");
	a_conv_time: assert property (cv_start && !busy_reg |-> ##1 s_conv_wait) else $error("conversion latency");
	a_done_pulse: assert property (cv_done |=> !cv_done) else $error("done longer than one cycle");
	a_ready_hold: assert property (ready |=> ready) else $error("ready dropped");
endmodule : dus_bank_properties

bind dus_bank dus_bank_properties #(.BUS_AVAIL(BUS_AVAIL), .CYC_PER_MS(CYC_PER_MS)) i_props (
	.clock(clock), .rst_n(rst_n), .od_req(od_req), .od_we(od_we), .od_index(od_index),
	.od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata),
	.cv_start(cv_start), .cv_done(cv_done), .ready(ready), .bus_enabled(bus_enabled));

// ### test/dus_od_master.sv
// dus_od_master: object dictionary master driving one access at a time.
// assumes answers come one edge after the request edge.
`timescale 1ns/1ns
module dus_od_master (
	// clock
	input wire logic        clock,
	// object access
	output logic            od_req,
	output logic            od_we,
	output logic [15:0]     od_index,
	output logic [31:0]     od_wdata,
	input wire logic        od_ack,
	input wire logic        od_err,
	input wire logic [31:0] od_rdata
);
	initial begin
		od_req = 1'b0;
		od_we = 1'b0;
		od_index = 16'h0000;
		od_wdata = 32'h00000000;
	end
	// released lines show the inverse of the last value
	task automatic access(input logic we, input logic [15:0] ix, input logic [31:0] wd,
		output logic [31:0] rd, output logic er, output logic ak);
		@(negedge clock);
		od_req = 1'b1;
		od_we = we;
		od_index = ix;
		od_wdata = wd;
		@(negedge clock);
		od_req = 1'b0;
		od_we = ~we;
		od_index = ~ix;
		od_wdata = ~wd;
		rd = od_rdata;
		er = od_err;
		ak = od_ack;
	endtask : access
endmodule : dus_od_master

// ### test/tb_top.sv
// tb_top: self-checking bench of the scaling and bus select bank.
// assumes the ms tick is shortened to 4 clock cycles.
`timescale 1ns/1ns
module tb_top;
	localparam logic [31:0] AVAIL = 32'h0001001A;
	logic        clock;
	logic        rst_n;
	logic        od_req;
	logic        od_we;
	logic [15:0] od_index;
	logic [31:0] od_wdata;
	logic        od_ack;
	logic        od_err;
	logic [31:0] od_rdata;
	logic        cv_start;
	logic [1:0]  cv_kind;
	logic [31:0] cv_value;
	logic [7:0]  pole_pairs;
	logic        cv_done;
	logic        cv_error;
	logic [31:0] cv_result;
	logic        ready;
	logic [31:0] bus_enabled;
	int          num_errors;
	int          cmp_count;
	int          cyc;
	int          seed;
	logic [31:0] mdl [int];
	logic [15:0] idx [11] = '{16'h2060, 16'h2061, 16'h2062, 16'h2063, 16'h2064, 16'h2065, 16'h2066,
		16'h2084, 16'h2101, 16'h2102, 16'h2103};
	int          bits [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 16, 17, 18, 31};

	dus_bank #(.BUS_AVAIL(AVAIL), .CYC_PER_MS(4)) i_dut (.clock(clock), .rst_n(rst_n), .od_req(od_req),
		.od_we(od_we), .od_index(od_index), .od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err),
		.od_rdata(od_rdata), .cv_start(cv_start), .cv_kind(cv_kind), .cv_value(cv_value),
		.pole_pairs(pole_pairs), .cv_done(cv_done), .cv_error(cv_error), .cv_result(cv_result),
		.ready(ready), .bus_enabled(bus_enabled));
	dus_od_master i_mst (.clock(clock), .od_req(od_req), .od_we(od_we), .od_index(od_index),
		.od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata));

	always #20 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_flag(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_flag

	task automatic init_mdl;
		foreach (idx[i])
			mdl[idx[i]] = (idx[i] inside {16'h2062, 16'h2064, 16'h2066}) ? 32'h3C : 32'h1;
		mdl[16'h2084] = 32'h0;
		mdl[16'h2101] = AVAIL;
		mdl[16'h2102] = 32'h8;
		mdl[16'h2103] = 32'h8;
	endtask : init_mdl

	task automatic rw(input logic we, input logic [15:0] ix, input logic [31:0] wd);
		logic [31:0] rd;
		logic        er;
		logic        ak;
		logic        bad;
		logic [31:0] e;
		bad = !mdl.exists(ix) || (we && ix inside {16'h2101, 16'h2103});
		bad = bad || (we && wd == 32'h0 && ix inside {16'h2062, 16'h2064, 16'h2066});
		e = mdl.exists(ix) ? mdl[ix] : 32'h0;
		i_mst.access(we, ix, wd, rd, er, ak);
		chk_flag("od_ack", 1'b1, ak);
		chk_word("od_rdata", e, rd);
		chk_flag("od_err", bad, er);
		if (we && !bad)
			mdl[ix] = wd;
		if (we && !bad && ix == 16'h2102)
			mdl[16'h2103] = wd & AVAIL & dus_pkg::BUS_DEFINED_MASK;
	endtask : rw

	task automatic busw(input logic [31:0] wd);
		rw(1'b1, 16'h2102, wd);
		@(negedge clock);
		mdl[16'h2103] = wd & AVAIL & dus_pkg::BUS_DEFINED_MASK;
		chk_word("bus_enabled", mdl[16'h2103], bus_enabled);
		rw(1'b0, 16'h2103, 32'h0);
	endtask : busw

	task automatic conv(input logic [1:0] k, input logic [31:0] val, input logic [7:0] pp);
		logic [15:0] b;
		logic [71:0] q;
		int          n;
		b = 16'h2061 + {13'h0, ((k == 2'h3) ? 2'h0 : k), 1'b0};
		q = 72'(val) * 72'(mdl[b]) * ((mdl[16'h2060] == 32'h1) ? 72'(pp) : 72'h1);
		q = q / 72'(mdl[b + 1]);
		@(negedge clock);
		cv_start = 1'b1;
		cv_kind = k;
		cv_value = val;
		pole_pairs = pp;
		@(negedge clock);
		cv_start = 1'b0;
		cv_value = ~val;
		n = 0;
		while (cv_done !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		chk_flag("cv_done", 1'b1, cv_done);
		chk_word("cv_result", q[31:0], cv_result);
		chk_flag("cv_error", |q[71:32], cv_error);
	endtask : conv

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		cv_start = 1'b0;
		cv_kind = 2'h0;
		cv_value = 32'h0;
		pole_pairs = 8'h0;
		num_errors = 0;
		cmp_count = 0;
		cyc = 0;
		seed = 32'h4b3f;
		init_mdl();
		for (int r = 0; r < 2; r++) begin
			repeat (2) @(negedge clock);
			chk_flag("ready", 1'b0, ready);
			chk_word("bus_enabled", 32'h8, bus_enabled);
			rst_n = 1'b1;
			@(negedge clock);
			chk_flag("ready", 1'b1, ready);
			foreach (idx[i])
				rw(1'b0, idx[i], 32'h0);
			rw(1'b0, 16'h2067, 32'h0);
			foreach (idx[i])
				rw(1'b1, idx[i], 32'($random(seed)));
			for (int k = 0; k < 3; k++)
				rw(1'b1, 16'h2062 + 16'(2 * k), 32'h0);
			foreach (idx[i])
				rw(1'b0, idx[i], 32'h0);
			foreach (bits[i])
				busw(32'h1 << bits[i]);
			busw(32'hFFFFFFFF);
			foreach (idx[i])
				rw(1'b0, idx[i], 32'h0);
			for (int c = 0; c < 3; c++) begin
				rw(1'b1, 16'h2060, 32'(c ^ 1));
				for (int k = 0; k < 4; k++)
					conv(2'(k), 32'($random(seed)) & 32'h000FFFFF, 8'($random(seed)));
			end
			@(negedge clock);
			rst_n = 1'b0;
			init_mdl();
		end
		final_report();
	end
endmodule : tb_top
